// ---- hdl/vmc_pkg.sv ----
// voltage match check: shared constants, types and register layout
// assumes a 32-bit Avalon-MM slave port with byte addresses
package vmc_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GLOB = 8'h04;
    localparam logic [7:0] OFS_REF = 8'h08;
    localparam logic [7:0] OFS_BRK = 8'h0C;
    localparam logic [7:0] OFS_LIVE = 8'h10;
    localparam logic [7:0] OFS_COND = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_EST = 8'h1C;
    localparam logic [7:0] OFS_ROT = 8'h20;
    localparam logic [7:0] OFS_ANG = 8'h24;

    // ****************************************
    // widths and timing
    // ****************************************
    localparam int NSTG = 3;
    localparam int NOBJ = 5;
    localparam int VW = 14;  // voltage, 0.01 %Un
    localparam int TW = 19;  // time, 5 ms steps
    localparam int AW = 20;  // angle, 0.001 deg
    localparam int TIME_STEP_US = 5000;
    localparam int BRK_DEF_US = 50000;
    localparam int BRK_DEF_STEPS = BRK_DEF_US / TIME_STEP_US;

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [2:0] {BEH_ON, BEH_BLK, BEH_TEST, BEH_TBLK, BEH_OFF} vmc_beh_e;
    typedef enum logic [2:0] {FRC_NORMAL, FRC_S1_BLK, FRC_S1_OK, FRC_S2_BLK, FRC_S2_OK,
        FRC_S3_BLK, FRC_S3_OK} vmc_frc_e;
    typedef enum logic [1:0] {ST_IDLE, ST_OK, ST_BLK} vmc_st_e;

    // ****************************************
    // register layouts
    // ****************************************
    typedef struct packed {
        logic [2:0] target;
        logic auto_close;
        logic [2:0] start_gate;
        logic [2:0] stage_en;
        logic ref_line;
        logic [2:0] force_sel;
        logic [2:0] behav;
    } vmc_ctrl_s;

    typedef struct packed {
        logic full_refs;
        logic ch4_chk;
        logic ch3_chk;
        logic force_en;
        logic allow_mode;
    } vmc_glob_s;

    typedef struct packed {
        logic s3_sel;
        logic [1:0] s2_ref;
        logic [2:0] s1_ref;
    } vmc_ref_s;

    typedef struct packed {
        logic v_ok;
        logic f_ok;
        logic a_ok;
        logic [VW-1:0] bus_v;
        logic [VW-1:0] line_v;
    } vmc_meas_s;

    typedef struct packed {
        logic [TW-1:0] est;
        logic [TW-1:0] rot;
        logic signed [AW-1:0] ang;
    } vmc_phase_s;

    // ****************************************
    // reset values
    // ****************************************
    localparam vmc_ctrl_s CTRL_RST = '0;
    localparam vmc_glob_s GLOB_RST = '0;
    localparam vmc_ref_s REF_RST = '0;
    localparam logic [TW-1:0] BRK_RST = TW'(BRK_DEF_STEPS);
    localparam logic [VW-1:0] LIVE_RST = 14'h07D0;  // 20.00 %Un
    localparam logic [14:0] COND_RST = 15'h0421;  // live-live only, each stage
    localparam logic [2:0] REF_LN_MIN = 3'h4;

endpackage : vmc_pkg

// ---- hdl/vmc_top.sv ----
// voltage match check: three stage decisions, blocking, forcing and auto close
// assumes cycle_tick marks each program cycle on ref_clk, block_in comes from
// same-clock logic, start requests come from pins
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - blocking input is sampled once per program cycle and used throughout
// - match with no blocking raises match_ok_out
// - match under blocking raises blocked_out and ends that event
// - blocking after match_ok_out drops match_ok_out
// - configuration locked until third or fourth channel is in check mode
// - behaviour On/Blocked/Test/Test-Blocked/Off, default On, only when allowed
// - force selector, default Normal, per stage blocked or ok, only when enabled
// - reference side select, default bus measured and line reference
// - each stage has an enable, default off; disabled stage is silent
// - start-gated mode checks only while start request is active
// - stage one reference: none, three line-line, three line-neutral per wiring
// - stage two line-line only, needs both channels in check mode
// - stage three enabled by third-versus-fourth selection, default none
// - auto close exists only for stage one, default off
// - auto close issues its own close command once matched
// - close is issued early by the breaker time, 5 ms steps, default 50 ms
// - close goes to one of five objects, default the first
// - remaining time to alignment published in 5 ms steps
// - full relative rotation time published in 5 ms steps
// - angle difference published within 360 degrees at 0.001 degree
// - match needs magnitude, frequency and angle all within limits
// - allowed live/dead combinations per stage or bypass, default live-live
// - side is live above the live threshold, default 20 %Un
module vmc_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // program cycle and inputs
    input wire logic cycle_tick,
    input wire logic [2:0] block_in,
    input wire logic [2:0] start_request_input,
    input wire vmc_pkg::vmc_meas_s meas [3],
    input wire vmc_pkg::vmc_phase_s phase,
    // decisions
    output logic [2:0] match_ok_out,
    output logic [2:0] blocked_out,
    output logic [4:0] close_cmd_out
);

    // ****************************************
    // register bus
    // ****************************************
    vmc_pkg::vmc_ctrl_s ctrl_q, ctrl_d;
    vmc_pkg::vmc_glob_s glob_q, glob_d;
    vmc_pkg::vmc_ref_s ref_q, ref_d;
    logic [vmc_pkg::TW-1:0] brk_q, brk_d;
    logic [vmc_pkg::VW-1:0] live_q, live_d;
    logic [14:0] cond_q, cond_d;
    logic ack_q, ack_d;
    logic [31:0] rd_q, rd_d;
    logic wr_go;
    logic cfg_ok;
    vmc_pkg::vmc_ctrl_s wc;
    vmc_pkg::vmc_ref_s wr;
    logic armed_q, armed_d;
    vmc_pkg::vmc_phase_s ph_q, ph_d;

    // one wait state, then answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata = rd_q;
    assign wr_go = avs_write & ack_q;
    assign cfg_ok = glob_q.ch3_chk | glob_q.ch4_chk;
    assign wc = vmc_pkg::vmc_ctrl_s'(avs_writedata[16:0]);
    assign wr = vmc_pkg::vmc_ref_s'(avs_writedata[5:0]);

    // register writes and read mux
    always_comb begin
        ack_d = (avs_read | avs_write) & ~ack_q;
        ctrl_d = ctrl_q;
        glob_d = glob_q;
        ref_d = ref_q;
        brk_d = brk_q;
        live_d = live_q;
        cond_d = cond_q;
        rd_d = rd_q;
        if (wr_go && avs_address == vmc_pkg::OFS_GLOB) begin
            glob_d = vmc_pkg::vmc_glob_s'(avs_writedata[4:0]);
        end
        if (wr_go && cfg_ok) begin
            unique case (avs_address)
                vmc_pkg::OFS_CTRL: begin
                    ctrl_d = wc;
                    if (!glob_q.allow_mode || wc.behav > 3'(vmc_pkg::BEH_OFF)) begin
                        ctrl_d.behav = ctrl_q.behav;
                    end
                    if (!glob_q.force_en || wc.force_sel > 3'(vmc_pkg::FRC_S3_OK)) begin
                        ctrl_d.force_sel = ctrl_q.force_sel;
                    end
                    if (wc.target >= 3'(vmc_pkg::NOBJ)) begin
                        ctrl_d.target = ctrl_q.target;
                    end
                end
                vmc_pkg::OFS_REF: begin
                    ref_d = wr;
                    if (wr.s1_ref == 3'h7 || (wr.s1_ref >= vmc_pkg::REF_LN_MIN && !glob_q.full_refs)) begin
                        ref_d.s1_ref = ref_q.s1_ref;
                    end
                end
                // breaker time in 5 ms steps
                vmc_pkg::OFS_BRK: brk_d = avs_writedata[vmc_pkg::TW-1:0];
                vmc_pkg::OFS_LIVE: live_d = avs_writedata[vmc_pkg::VW-1:0];
                vmc_pkg::OFS_COND: cond_d = avs_writedata[14:0];
                default: ;
            endcase
        end
        if (!ack_q) begin
            unique case (avs_address)
                vmc_pkg::OFS_CTRL: rd_d = {15'h0000, ctrl_q};
                vmc_pkg::OFS_GLOB: rd_d = {27'h0000000, glob_q};
                vmc_pkg::OFS_REF: rd_d = {26'h0000000, ref_q};
                vmc_pkg::OFS_BRK: rd_d = {13'h0000, brk_q};
                vmc_pkg::OFS_LIVE: rd_d = {18'h00000, live_q};
                vmc_pkg::OFS_COND: rd_d = {17'h00000, cond_q};
                vmc_pkg::OFS_STAT: rd_d = {24'h000000, armed_q, cfg_ok, blocked_out, match_ok_out};
                vmc_pkg::OFS_EST: rd_d = {13'h0000, ph_q.est};
                vmc_pkg::OFS_ROT: rd_d = {13'h0000, ph_q.rot};
                vmc_pkg::OFS_ANG: rd_d = {{12{ph_q.ang[vmc_pkg::AW-1]}}, ph_q.ang};
                default: rd_d = 32'h00000000;
            endcase
        end
    end

    // register bus flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            rd_q <= 32'h00000000;
            ctrl_q <= vmc_pkg::CTRL_RST;
            glob_q <= vmc_pkg::GLOB_RST;
            ref_q <= vmc_pkg::REF_RST;
            brk_q <= vmc_pkg::BRK_RST;
            live_q <= vmc_pkg::LIVE_RST;
            cond_q <= vmc_pkg::COND_RST;
        end else begin
            ack_q <= ack_d;
            rd_q <= rd_d;
            ctrl_q <= ctrl_d;
            glob_q <= glob_d;
            ref_q <= ref_d;
            brk_q <= brk_d;
            live_q <= live_d;
            cond_q <= cond_d;
        end
    end

    // ****************************************
    // input capture per program cycle
    // ****************************************
    logic [2:0] s1_q, s2_q, s3_q, start_q, start_d;
    logic [2:0] blk_q, blk_d;
    logic eval_q;
    vmc_pkg::vmc_meas_s ms_q [3];
    vmc_pkg::vmc_meas_s ms_d [3];

    // start debounce and cycle latch
    always_comb begin
        start_d = start_q;
        for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                start_d[i] = s3_q[i];
            end
        end
        blk_d = cycle_tick ? block_in : blk_q;
        ph_d = cycle_tick ? phase : ph_q;
        for (int i = 0; i < 3; i++) begin
            ms_d[i] = cycle_tick ? meas[i] : ms_q[i];
        end
    end

    // capture flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            start_q <= 3'h0;
            blk_q <= 3'h0;
            eval_q <= 1'b0;
            ph_q <= '0;
            for (int i = 0; i < 3; i++) begin
                ms_q[i] <= '0;
            end
        end else begin
            s1_q <= start_request_input;
            s2_q <= s1_q;
            s3_q <= s2_q;
            start_q <= start_d;
            blk_q <= blk_d;
            eval_q <= cycle_tick;
            ph_q <= ph_d;
            for (int i = 0; i < 3; i++) begin
                ms_q[i] <= ms_d[i];
            end
        end
    end

    // ****************************************
    // stage decisions
    // ****************************************
    vmc_pkg::vmc_beh_e beh;
    logic gblk, outs_on;
    logic [2:0] avl, run, act, mt, bk, f_ok, f_bk;
    vmc_pkg::vmc_st_e st_q [3];
    vmc_pkg::vmc_st_e st_d [3];

    assign beh = glob_q.allow_mode ? vmc_pkg::vmc_beh_e'(ctrl_q.behav) : vmc_pkg::BEH_ON;
    assign gblk = beh == vmc_pkg::BEH_BLK || beh == vmc_pkg::BEH_TBLK;
    assign outs_on = beh == vmc_pkg::BEH_ON || beh == vmc_pkg::BEH_BLK;
    assign avl[0] = cfg_ok & (ref_q.s1_ref != 3'h0);
    assign avl[1] = glob_q.ch3_chk & glob_q.ch4_chk & (ref_q.s2_ref != 2'h0);
    assign avl[2] = cfg_ok & ref_q.s3_sel;

    // per-stage qualifiers
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic ml, rl;
            logic [1:0] idx;
            ml = 1'b0;
            rl = 1'b0;
            idx = 2'h0;
            act[i] = avl[i] & ctrl_q.stage_en[i] & (beh != vmc_pkg::BEH_OFF);
            run[i] = act[i] & (~ctrl_q.start_gate[i] | start_q[i]);
            ml = (ctrl_q.ref_line ? ms_q[i].line_v : ms_q[i].bus_v) > live_q;
            rl = (ctrl_q.ref_line ? ms_q[i].bus_v : ms_q[i].line_v) > live_q;
            idx = {~ml, ~rl};
            mt[i] = ms_q[i].v_ok & ms_q[i].f_ok & ms_q[i].a_ok
                & (cond_q[5*i+4] | cond_q[5*i+idx]);
            bk[i] = blk_q[i] | gblk;
            f_bk[i] = glob_q.force_en && ctrl_q.force_sel == 3'(2*i+1);
            f_ok[i] = glob_q.force_en && ctrl_q.force_sel == 3'(2*i+2);
        end
    end

    // stage state next
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            st_d[i] = st_q[i];
            if (eval_q) begin
                if (!run[i]) begin
                    st_d[i] = vmc_pkg::ST_IDLE;
                end else begin
                    unique case (st_q[i])
                        vmc_pkg::ST_IDLE: if (mt[i]) begin
                            st_d[i] = bk[i] ? vmc_pkg::ST_BLK : vmc_pkg::ST_OK;
                        end
                        vmc_pkg::ST_OK: if (bk[i] || !mt[i]) begin
                            st_d[i] = vmc_pkg::ST_IDLE;
                        end
                        vmc_pkg::ST_BLK: if (!mt[i]) begin
                            st_d[i] = vmc_pkg::ST_IDLE;
                        end
                        default: st_d[i] = vmc_pkg::ST_IDLE;
                    endcase
                end
            end
        end
    end

    // stage state flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 3; i++) begin
                st_q[i] <= vmc_pkg::ST_IDLE;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                st_q[i] <= st_d[i];
            end
        end
    end

    // ****************************************
    // outputs and auto close
    // ****************************************
    logic [2:0] ok_d, bo_d;
    logic [4:0] cl_d;

    // output decode and close timing
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ok_d[i] = act[i] & outs_on & (f_ok[i] | (~f_bk[i] & (st_d[i] == vmc_pkg::ST_OK)));
            bo_d[i] = act[i] & outs_on & (f_bk[i] | (~f_ok[i] & (st_d[i] == vmc_pkg::ST_BLK)));
        end
        cl_d = 5'h00;
        armed_d = armed_q;
        if (eval_q) begin
            if (!ok_d[0] || ph_q.est > brk_q) begin
                armed_d = 1'b1;
            end else if (ctrl_q.auto_close && armed_q) begin
                cl_d[ctrl_q.target] = 1'b1;
                armed_d = 1'b0;
            end
        end
    end

    // output flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            match_ok_out <= 3'h0;
            blocked_out <= 3'h0;
            close_cmd_out <= 5'h00;
            armed_q <= 1'b1;
        end else begin
            match_ok_out <= ok_d;
            blocked_out <= bo_d;
            close_cmd_out <= cl_d;
            armed_q <= armed_d;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    AST_BLK_SAMPLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cycle_tick |=> blk_q == $past(block_in))
        else $error("block not sampled at cycle start");
    AST_BLK_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !cycle_tick |=> $stable(blk_q))
        else $error("block changed between cycle starts");
    AST_OK_RISE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        eval_q && run[0] && st_q[0] == vmc_pkg::ST_IDLE && mt[0] && !bk[0]
        |=> st_q[0] == vmc_pkg::ST_OK)
        else $error("match without blocking not ok");
    AST_BLK_RISE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        eval_q && run[0] && st_q[0] == vmc_pkg::ST_IDLE && mt[0] && bk[0]
        |=> st_q[0] == vmc_pkg::ST_BLK)
        else $error("blocked match not flagged");
    AST_OK_DROP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        eval_q && st_q[0] == vmc_pkg::ST_OK && bk[0] && !f_ok[0] |=> !match_ok_out[0])
        else $error("ok kept under blocking");
    AST_DISABLED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !ctrl_q.stage_en[2] |=> !match_ok_out[2] && !blocked_out[2])
        else $error("disabled stage drives output");
    AST_LOCK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_go && !cfg_ok && avs_address == vmc_pkg::OFS_CTRL |=> $stable(ctrl_q))
        else $error("config written while locked");
    AST_CLOSE_ONCE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        close_cmd_out != 5'h00 |=> close_cmd_out == 5'h00 && !armed_q)
        else $error("close repeated");
    AST_CLOSE_EN: assert property (@(posedge ref_clk) disable iff (!arst_n)
        close_cmd_out != 5'h00 |-> $past(ctrl_q.auto_close) && $past(ph_q.est) <= $past(brk_q))
        else $error("close without enable or early");
    AST_FORCE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        f_ok[0] && act[0] && outs_on |=> match_ok_out[0] && !blocked_out[0])
        else $error("forced ok not shown");
    AST_START: assert property (@(posedge ref_clk) disable iff (!arst_n)
        eval_q && ctrl_q.start_gate[0] && !start_q[0] |=> st_q[0] == vmc_pkg::ST_IDLE)
        else $error("checking without start");

endmodule : vmc_top

`default_nettype wire

// ---- bench/vmc_far_model.sv ----
// far side of vmc_top: blocking matrix, start pins, program cycle, breaker objects
// assumes the same clock and reset as the block; the bench sets block and start levels
`timescale 1ns/1ps
`default_nettype none
module vmc_far_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // levels chosen by the bench
    input wire logic [2:0] blk_set,
    input wire logic [2:0] start_set,
    // block side
    output logic cycle_tick,
    output logic [2:0] block_in,
    output logic [2:0] start_request_input,
    input wire logic [4:0] close_cmd_out,
    // close pulses seen per object
    output int close_cnt [5]
);
    logic [2:0] div_q;

    // program cycle tick, one clock in eight
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 3'h0;
            cycle_tick <= 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
            cycle_tick <= (div_q == 3'h7);
        end
    end

    assign block_in = blk_set;
    assign start_request_input = start_set;

    // breaker objects count close pulses
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            close_cnt <= '{default: 0};
        end else begin
            for (int i = 0; i < 5; i++) close_cnt[i] <= close_cnt[i] + int'(close_cmd_out[i]);
        end
    end
endmodule : vmc_far_model
`default_nettype wire

// ---- bench/tb.sv ----
// bench for vmc_top: registers, stage decisions, forcing, gating, auto close
// assumes vmc_far_model as far side and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk, arst_n, avs_read, avs_write, avs_waitrequest, cycle_tick;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0] block_in, start_request_input, match_ok_out, blocked_out, blk_set, start_set;
    logic [4:0] close_cmd_out;
    vmc_pkg::vmc_meas_s meas [3];
    vmc_pkg::vmc_phase_s phase;
    vmc_pkg::vmc_st_e st;
    int close_cnt [5];
    int error_cnt = 0;
    int n_checks = 0;
    localparam logic [30:0] MOK = {3'h7, 14'h0800, 14'h0800};

    vmc_top dut_u (.ref_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .cycle_tick, .block_in, .start_request_input,
        .meas, .phase, .match_ok_out, .blocked_out, .close_cmd_out);
    vmc_far_model far_u (.ref_clk, .arst_n, .blk_set, .start_set, .cycle_tick, .block_in,
        .start_request_input, .close_cmd_out, .close_cnt);

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic hang(input string m);
        error_cnt++;
        $display("wrong value at %0t: %s wait ran out", $time, m);
        report_and_stop();
    endtask : hang

    task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : ck

    // one avalon transfer, held until waitrequest is low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 40) hang("bus");
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rdck(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        ck(rd, e, "read");
    endtask : rdck

    // wait for a tick, then until its outputs settle
    task automatic cyc;
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge ref_clk);
            if (cycle_tick === 1'b1) break;
        end
        if (i == 20) hang("tick");
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : cyc

    task automatic go(input logic [30:0] mv, input logic b);
        @(posedge ref_clk);
        meas[0] <= mv;
        blk_set[0] <= b;
        cyc();
    endtask : go

    // expected stage state after one evaluation
    function automatic vmc_pkg::vmc_st_e nxt(vmc_pkg::vmc_st_e s, logic m, logic b);
        if (!m) return vmc_pkg::ST_IDLE;
        if (s == vmc_pkg::ST_BLK || (s == vmc_pkg::ST_IDLE && b)) return vmc_pkg::ST_BLK;
        return b ? vmc_pkg::ST_IDLE : vmc_pkg::ST_OK;
    endfunction : nxt

    task automatic step(input logic [30:0] mv, input logic b);
        st = nxt(st, (&mv[30:28]) && mv[27:14] > vmc_pkg::LIVE_RST && mv[13:0] > vmc_pkg::LIVE_RST, b);
        go(mv, b);
        ck(match_ok_out[0], st == vmc_pkg::ST_OK, "ok");
        ck(blocked_out[0], st == vmc_pkg::ST_BLK, "blocked");
    endtask : step

    initial begin
        arst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        blk_set = 3'h0;
        start_set = 3'h0;
        meas = '{default: '0};
        phase = '0;
        st = vmc_pkg::ST_IDLE;
        void'($urandom(70));
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdck(vmc_pkg::OFS_BRK, 32'(vmc_pkg::BRK_RST));
        rdck(vmc_pkg::OFS_LIVE, 32'(vmc_pkg::LIVE_RST));
        rdck(vmc_pkg::OFS_COND, 32'(vmc_pkg::COND_RST));
        rdck(vmc_pkg::OFS_CTRL, 32'h0);
        rdck(8'h3C, 32'h0); // unmapped reads zero
        bus(1'b1, vmc_pkg::OFS_CTRL, 32'h80);
        rdck(vmc_pkg::OFS_CTRL, 32'h0); // locked write dropped
        $display("test reset and lock done");
        bus(1'b1, vmc_pkg::OFS_GLOB, 32'h07);
        bus(1'b1, vmc_pkg::OFS_REF, 32'h01);
        bus(1'b1, vmc_pkg::OFS_CTRL, 32'h80);
        rdck(vmc_pkg::OFS_CTRL, 32'h80);
        step(MOK, 1'b0);
        repeat (6) @(posedge ref_clk);
        blk_set[0] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        blk_set[0] <= 1'b0;
        @(negedge ref_clk);
        ck(match_ok_out[0], 1'b1, "block raised after tick");
        step(MOK, 1'b1);
        step(MOK, 1'b1);
        step(MOK, 1'b0);
        step({3'h6, 28'h0800800}, 1'b0);
        step({3'h7, 14'h07D0, 14'h0800}, 1'b0);
        step({3'h7, 14'h07D1, 14'h07D1}, 1'b0);
        repeat (40) step({3'($urandom), 14'h07CF + 14'($urandom_range(0, 2)),
            14'h07CF + 14'($urandom_range(0, 2))}, 1'($urandom));
        $display("test decisions done");
        bus(1'b1, vmc_pkg::OFS_CTRL, 32'h90);
        go(31'h0, 1'b0);
        ck(match_ok_out[0], 1'b1, "forced ok");
        bus(1'b1, vmc_pkg::OFS_CTRL, 32'h88);
        go(MOK, 1'b0);
        ck(blocked_out[0], 1'b1, "forced blocked");
        for (int b = 1; b < 5; b++) begin
            bus(1'b1, vmc_pkg::OFS_CTRL, 32'h80 | b);
            go(MOK, 1'b0);
            ck(match_ok_out[0], 1'b0, "mode");
        end
        bus(1'b1, vmc_pkg::OFS_CTRL, 32'h480);
        st = vmc_pkg::ST_IDLE;
        step(31'h0, 1'b0);
        go(MOK, 1'b0);
        cyc();
        ck(match_ok_out[0], 1'b0, "no start");
        @(posedge ref_clk);
        start_set <= 3'h1;
        cyc();
        cyc();
        ck(match_ok_out[0], 1'b1, "start");
        bus(1'b1, vmc_pkg::OFS_CTRL, 32'h80);
        bus(1'b1, vmc_pkg::OFS_COND, 32'h0430);
        go({3'h7, 28'h0}, 1'b0);
        ck(match_ok_out[0], 1'b1, "bypass");
        bus(1'b1, vmc_pkg::OFS_COND, 32'h0422);
        go({3'h7, 14'h0800, 14'h0}, 1'b0);
        ck(match_ok_out[0], 1'b1, "bus measured");
        bus(1'b1, vmc_pkg::OFS_CTRL, 32'hC0);
        go({3'h7, 14'h0800, 14'h0}, 1'b0);
        ck(match_ok_out[0], 1'b0, "line measured");
        bus(1'b1, vmc_pkg::OFS_COND, 32'h0421);
        $display("test force mode start done");
        for (int t = 0; t < 5; t++) begin
            bus(1'b1, vmc_pkg::OFS_CTRL, 32'h2080 | (t << 14));
            phase.est <= 19'd20;
            go(MOK, 1'b0);
            @(posedge ref_clk);
            phase.est <= 19'd10;
            cyc();
            cyc();
        end
        for (int t = 0; t < 5; t++) ck(close_cnt[t], 32'h1, "close count");
        @(posedge ref_clk);
        phase <= {19'h00123, 19'h00456, -20'sd5};
        cyc();
        rdck(vmc_pkg::OFS_EST, 32'h123);
        rdck(vmc_pkg::OFS_ROT, 32'h456);
        rdck(vmc_pkg::OFS_ANG, 32'hFFFFFFFB);
        $display("test auto close and publish done");
        bus(1'b1, vmc_pkg::OFS_REF, 32'h2C);
        rdck(vmc_pkg::OFS_REF, 32'h29);
        bus(1'b1, vmc_pkg::OFS_CTRL, 32'h380);
        @(posedge ref_clk);
        meas <= '{MOK, MOK, MOK};
        cyc();
        ck(match_ok_out, 32'h5, "stage two locked out");
        bus(1'b1, vmc_pkg::OFS_GLOB, 32'h0F);
        cyc();
        ck(match_ok_out, 32'h7, "all stages");
        $display("test stages done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
